// [logic/asr_port.sv]
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// [RULE1] Select high resets port, output released
// [RULE2] Select low shows ready level at once
// [RULE3] Result snapshot held for whole transfer
// [RULE4] Clock low 28 ms restarts transfer
// [RULE5] Controller keeps clock low when idle
// [RULE6] Sample input on falling edges, never drive
// [RULE7] Shift output bits on rising edges
// [RULE8] Output goes low when result ready
// [RULE9] Unread result: high 8 us early
// [RULE10] Controller reads before ready returns high
// [RULE11] Weak pull-up while deselected unless disabled
// [RULE12] Twelve-bit two's complement, left aligned
// [RULE13] Clip at 7FF0h and 8000h, step 0010h
// [RULE14] Mode 0 converts back to back always
// [RULE15] Mode 1 converts only on trigger
// [RULE16] Latest result buffered until overwritten
// [RULE17] Bit 15 first, config captured meanwhile
// [RULE18] Frames are 32 bits or 16 bits
// [RULE19] Result bytes then config readback bytes
// [RULE20] Controller repeats or holds config input
// [RULE21] Select high after 16 clocks resets
// [RULE22] Result zero at power-up, low nibble zero
// [RULE23] Trigger reads 0, starts only when down
// [RULE24] Mode resets to 1, powers down after
// [RULE25] Pins synchronised, time-out from own clock
module asr_port
	import asr_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = TIMEOUT_CYCLES_DEF,
	parameter int unsigned CONV_CYCLES = CONV_CYCLES_DEF
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Serial pins
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic DIN,
	output logic DOUT_O,
	output logic DOUT_OE,
	output logic DOUT_PULLUP,
	// Modulator side
	input wire logic signed [SAMPLE_W-1:0] ADC_SAMPLE,
	output logic CONV_ACTIVE,
	output logic [WORD_BITS-1:0] CFG_OUT
);

	// ==========================================================
	// Elaboration checks
	localparam int unsigned TW = $clog2(TIMEOUT_CYCLES + 1);
	localparam int unsigned CW = $clog2(CONV_CYCLES + 1);
	localparam logic [TW-1:0] TMO_LAST = TW'(TIMEOUT_CYCLES - 1);
	localparam logic [CW-1:0] CONV_LAST = CW'(CONV_CYCLES - 1);
	localparam logic [CW-1:0] HIDE_AT =
		CW'(CONV_CYCLES - DRDY_LEAD_CYCLES - 1);

	generate
		if (TIMEOUT_CYCLES < 2) begin : g_bad_tmo
			$error("TIMEOUT_CYCLES must be at least 2");
		end
		if (CONV_CYCLES <= DRDY_LEAD_CYCLES + 1) begin : g_bad_conv
			$error("CONV_CYCLES must exceed the ready lead time");
		end
	endgenerate

	// ==========================================================
	// Pin synchronisers and edge detection
	asr_pins_t pins_raw;
	asr_pins_t pins_s;
	logic sclk_d_reg;
	logic sclk_rise;
	logic sclk_fall;
	logic selected;

	assign pins_raw = '{cs_n: CS_N, sclk: SCLK, din: DIN};

	asr_sync #(
		.WIDTH(3),
		.RESET_VAL(3'h4)
	) u_sync (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.d(pins_raw),
		.q(pins_s)
	); // [RULE25]

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			sclk_d_reg <= 1'b0;
		end else begin
			sclk_d_reg <= pins_s.sclk;
		end
	end

	assign selected = ~pins_s.cs_n;
	// Edges are ignored while deselected
	assign sclk_rise = selected & pins_s.sclk & ~sclk_d_reg; // [RULE1]
	assign sclk_fall = selected & ~pins_s.sclk & sclk_d_reg; // [RULE6]

	// ==========================================================
	// Idle clock time-out
	logic [TW-1:0] tmo_cnt_reg;
	logic tmo_hit;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			tmo_cnt_reg <= '0;
		end else if (pins_s.sclk) begin
			tmo_cnt_reg <= '0;
		end else if (tmo_cnt_reg != TMO_LAST) begin
			tmo_cnt_reg <= tmo_cnt_reg + 1'b1; // [RULE25]
		end
	end

	// Gated by the pin so the first rise after a long idle opens a frame
	assign tmo_hit = ~pins_s.sclk & (tmo_cnt_reg == TMO_LAST); // [RULE4]

	// ==========================================================
	// Frame control
	logic in_frame_reg;
	logic [5:0] bit_cnt_reg;
	logic frame_start;
	logic frame_abort;
	logic half_done;
	logic [WORD_BITS-1:0] rx_word;
	logic [WORD_BITS-1:0] rx_reg;
	asr_cfg_t cfg_reg;
	asr_cfg_t cfg_next;
	logic key_ok;

	assign frame_start = sclk_rise & ~in_frame_reg; // [RULE17]
	assign frame_abort = ~selected | tmo_hit; // [RULE1] [RULE4] [RULE21]
	assign half_done = sclk_fall & (bit_cnt_reg == BITS_HALF - 1'b1);
	assign rx_word = {rx_reg[WORD_BITS-2:0], pins_s.din};

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			in_frame_reg <= 1'b0;
			bit_cnt_reg <= '0;
		end else if (frame_abort) begin
			in_frame_reg <= 1'b0;
			bit_cnt_reg <= '0;
		end else begin
			if (frame_start) begin
				in_frame_reg <= 1'b1;
			end
			if (sclk_fall && in_frame_reg) begin
				if (bit_cnt_reg == BITS_FRAME - 1'b1) begin
					in_frame_reg <= 1'b0; // [RULE18]
					bit_cnt_reg <= '0;
				end else begin
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// Receive shift register
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			rx_reg <= '0;
		end else if (sclk_fall && in_frame_reg) begin
			rx_reg <= rx_word; // [RULE6] [RULE17]
		end
	end

	// ==========================================================
	// Configuration word
	always_comb begin
		cfg_next = asr_cfg_t'(rx_word);
		cfg_next.single_shot = 1'b0; // [RULE23]
		cfg_next.reserved = RESERVED_READ;
	end

	assign key_ok = (cfg_next.write_key == WRITE_KEY_VALID);

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			cfg_reg <= asr_cfg_t'(CFG_RESET); // [RULE24]
		end else if (half_done && in_frame_reg && key_ok) begin
			cfg_reg <= cfg_next;
		end
	end

	// ==========================================================
	// Conversion sequencer
	asr_conv_t conv_state_reg;
	logic [CW-1:0] conv_cnt_reg;
	logic trig_req;
	logic push_valid;
	logic push_ready;
	logic [WORD_BITS-1:0] push_code;

	// Trigger counts only with a valid key and when powered down
	assign trig_req = half_done & in_frame_reg & key_ok &
		rx_word[WORD_BITS-1] & (cfg_next.mode == MODE_SINGLE);
	assign push_valid = (conv_state_reg == CV_PUSH);

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			conv_state_reg <= CV_DOWN;
			conv_cnt_reg <= '0;
		end else begin
			case (conv_state_reg)
				CV_DOWN: begin
					conv_cnt_reg <= '0;
					if (cfg_reg.mode == MODE_CONTINUOUS) begin
						conv_state_reg <= CV_RUN; // [RULE14]
					end else if (trig_req) begin
						conv_state_reg <= CV_RUN; // [RULE15] [RULE23]
					end
				end
				CV_RUN: begin
					if (conv_cnt_reg == CONV_LAST) begin
						conv_state_reg <= CV_PUSH;
					end else begin
						conv_cnt_reg <= conv_cnt_reg + 1'b1;
					end
				end
				CV_PUSH: begin
					conv_cnt_reg <= '0;
					if (push_ready) begin
						if (cfg_reg.mode == MODE_CONTINUOUS) begin
							conv_state_reg <= CV_RUN; // [RULE14]
						end else begin
							conv_state_reg <= CV_DOWN; // [RULE24]
						end
					end
				end
				default: begin
					conv_state_reg <= CV_DOWN;
					conv_cnt_reg <= '0;
				end
			endcase
		end
	end

	// ==========================================================
	// Output coding with clipping
	always_comb begin
		if (ADC_SAMPLE > SAMPLE_POS_FS) begin
			push_code = CODE_POS_CLIP; // [RULE13]
		end else if (ADC_SAMPLE < SAMPLE_NEG_FS) begin
			push_code = CODE_NEG_CLIP; // [RULE13]
		end else begin
			// One sample step is CODE_STEP
			push_code = {ADC_SAMPLE[11:0], RESULT_LOW_ZERO}; // [RULE12]
		end
	end

	// ==========================================================
	// Result buffer and result register
	logic buf_valid;
	logic buf_ready;
	logic [WORD_BITS-1:0] buf_data;
	logic commit;
	logic [WORD_BITS-1:0] result_reg;

	asr_fifo2 #(
		.WIDTH(WORD_BITS),
		.DEPTH(2)
	) u_buf (
		.clk(CLK_SYS),
		.reset_n(RESET_N),
		.in_valid(push_valid),
		.in_ready(push_ready),
		.in_data(push_code),
		.out_valid(buf_valid),
		.out_ready(buf_ready),
		.out_data(buf_data)
	);

	// Stall one cycle so a snapshot and a commit never collide
	assign buf_ready = ~frame_start;
	assign commit = buf_valid & buf_ready;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			result_reg <= RESULT_RESET; // [RULE22]
		end else if (commit) begin
			result_reg <= {buf_data[15:4], RESULT_LOW_ZERO}; // [RULE16] [RULE22]
		end
	end

	// ==========================================================
	// Data-ready tracking
	logic new_reg;
	logic hide_reg;
	logic ready_n;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			new_reg <= 1'b0;
		end else if (commit) begin
			new_reg <= 1'b1; // [RULE8]
		end else if (frame_start) begin
			new_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			hide_reg <= 1'b0;
		end else if (commit) begin
			hide_reg <= 1'b0;
		end else if (new_reg && conv_state_reg == CV_RUN &&
			cfg_reg.mode == MODE_CONTINUOUS && conv_cnt_reg == HIDE_AT) begin
			hide_reg <= 1'b1; // [RULE9] [RULE10]
		end
	end

	assign ready_n = ~(new_reg & ~hide_reg); // [RULE8] [RULE21]

	// ==========================================================
	// Transmit shift register
	logic [WORD_BITS-1:0] tx_reg;

	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			tx_reg <= '0;
		end else if (frame_start) begin
			tx_reg <= {result_reg[WORD_BITS-2:0], 1'b0}; // [RULE3]
		end else if (sclk_rise && in_frame_reg) begin
			tx_reg <= {tx_reg[WORD_BITS-2:0], 1'b0}; // [RULE7]
		end else if (half_done && in_frame_reg) begin
			// Readback reflects the word taken in the first half, or cfg_reg if its key is invalid
			tx_reg <= key_ok ? cfg_next : cfg_reg; // [RULE19]
		end
	end

	// ==========================================================
	// Pin drivers
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			DOUT_O <= 1'b1;
			DOUT_OE <= 1'b0;
			DOUT_PULLUP <= 1'b1;
		end else begin
			DOUT_OE <= selected; // [RULE1]
			DOUT_PULLUP <= ~selected & cfg_reg.output_pullup_enable; // [RULE11]
			if (!selected) begin
				DOUT_O <= 1'b1;
			end else if (frame_start) begin
				DOUT_O <= result_reg[WORD_BITS-1]; // [RULE17]
			end else if (sclk_rise && in_frame_reg) begin
				DOUT_O <= tx_reg[WORD_BITS-1]; // [RULE7] [RULE19]
			end else if (!in_frame_reg || frame_abort) begin
				DOUT_O <= ready_n; // [RULE2] [RULE8]
			end
		end
	end

	// ==========================================================
	// Modulator side outputs
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) begin
			CONV_ACTIVE <= 1'b0;
			CFG_OUT <= CFG_RESET;
		end else begin
			CONV_ACTIVE <= (conv_state_reg != CV_DOWN);
			CFG_OUT <= cfg_reg;
		end
	end

endmodule : asr_port
`default_nettype wire

// [logic/asr_pkg.sv]
`default_nettype none
package asr_pkg;

	// ==========================================================
	// Configuration word layout, most significant field first
	typedef struct packed {
		logic single_shot;
		logic [2:0] input_mux;
		logic [2:0] gain;
		logic mode;
		logic [2:0] rate;
		logic temp_mode;
		logic output_pullup_enable;
		logic [1:0] write_key;
		logic reserved;
	} asr_cfg_t;

	// Synchronised pin group
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic din;
	} asr_pins_t;

	// ==========================================================
	// Reset values and fixed codes
	localparam logic [15:0] CFG_RESET = 16'h058B;
	localparam logic [15:0] RESULT_RESET = 16'h0000;
	localparam logic [1:0] WRITE_KEY_VALID = 2'h1;
	localparam logic MODE_CONTINUOUS = 1'b0;
	localparam logic MODE_SINGLE = 1'b1;
	localparam logic RESERVED_READ = 1'b1;
	localparam logic [15:0] CODE_POS_CLIP = 16'h7FF0;
	localparam logic [15:0] CODE_NEG_CLIP = 16'h8000;
	localparam logic [15:0] CODE_STEP = 16'h0010;
	localparam logic [3:0] RESULT_LOW_ZERO = 4'h0;

	// ==========================================================
	// Sample from the modulator, in result steps
	localparam int unsigned SAMPLE_W = 14;
	localparam logic signed [13:0] SAMPLE_POS_FS = 14'sh07FF;
	localparam logic signed [13:0] SAMPLE_NEG_FS = 14'sh3800;

	// ==========================================================
	// Frame geometry
	localparam int unsigned WORD_BITS = 16;
	localparam int unsigned FRAME_BITS = 32;
	localparam logic [5:0] BITS_HALF = 6'h10;
	localparam logic [5:0] BITS_FRAME = 6'h20;

	// ==========================================================
	// Timing
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned TIMEOUT_MS = 28;
	localparam int unsigned DRDY_LEAD_US = 8;
	localparam int unsigned TIMEOUT_CYCLES_DEF = TIMEOUT_MS * CLK_MHZ * 1000;
	localparam int unsigned DRDY_LEAD_CYCLES = DRDY_LEAD_US * CLK_MHZ;
	localparam int unsigned CONV_CYCLES_DEF = 62500;

	// ==========================================================
	// Conversion sequencer
	typedef enum logic [1:0] {
		CV_DOWN = 2'b00,
		CV_RUN = 2'b01,
		CV_PUSH = 2'b10
	} asr_conv_t;

endpackage : asr_pkg
`default_nettype wire

// [logic/asr_sync.sv]
`timescale 1ns/1ns
`default_nettype none
module asr_sync #(
	parameter int unsigned WIDTH = 3,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_reg;

	// First stage is read by the second stage only
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end

endmodule : asr_sync
`default_nettype wire

// [logic/asr_fifo2.sv]
`timescale 1ns/1ns
`default_nettype none
module asr_fifo2 #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	generate
		if (DEPTH != 2) begin : g_bad_depth
			$error("asr_fifo2 holds exactly two entries");
		end
	endgenerate

	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [PW-1:0] wr_reg;
	logic [PW-1:0] rd_reg;
	logic [PW:0] cnt_reg;
	logic push;
	logic pop;

	assign in_ready = (cnt_reg != (PW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= '0;
			end
		end else if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= rd_reg + 1'b1;
			end
			if (push && !pop) begin
				cnt_reg <= cnt_reg + 1'b1;
			end else if (pop && !push) begin
				cnt_reg <= cnt_reg - 1'b1;
			end
		end
	end

endmodule : asr_fifo2
`default_nettype wire

// [testbench/asr_port_props.sv]
`timescale 1ns/1ns
`default_nettype none
module asr_port_props
	import asr_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYCLES = 200,
	parameter int unsigned CONV_CYCLES = 1200
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESET_N,
	// Serial pins
	input wire logic CS_N,
	input wire logic SCLK,
	input wire logic DIN,
	input wire logic DOUT_O,
	input wire logic DOUT_OE,
	input wire logic DOUT_PULLUP,
	// Modulator side
	input wire logic signed [SAMPLE_W-1:0] ADC_SAMPLE,
	input wire logic CONV_ACTIVE,
	input wire logic [WORD_BITS-1:0] CFG_OUT
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RESET_N);
	logic [15:0] sclk_hist;
	logic [31:0] act_cnt;
	// Pin history: config updates trail a falling clock edge
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) sclk_hist <= '0;
		else sclk_hist <= {sclk_hist[14:0], SCLK};
	end
	always_ff @(posedge CLK_SYS or negedge RESET_N) begin
		if (!RESET_N) act_cnt <= '0;
		else if (!CONV_ACTIVE || !CFG_OUT[8]) act_cnt <= '0;
		else act_cnt <= act_cnt + 1;
	end
	property p_desel; CS_N [*4] |-> !DOUT_OE && DOUT_O; endproperty
	a_desel: assert property (p_desel) else $error("pin driven");
	property p_sel; !CS_N [*5] |-> DOUT_OE; endproperty
	a_sel: assert property (p_sel) else $error("pin not driven");
	property p_pull; CS_N [*4] |-> DOUT_PULLUP == CFG_OUT[3]; endproperty
	a_pull: assert property (p_pull) else $error("pull-up wrong");
	property p_trig; CFG_OUT[15] == 1'b0 && CFG_OUT[0]; endproperty
	a_trig: assert property (p_trig) else $error("trigger bit");
	property p_cfg; $changed(CFG_OUT) |-> |sclk_hist[15:2]; endproperty
	a_cfg: assert property (p_cfg) else $error("config moved");
	property p_cont; !CFG_OUT[8] |-> ##[0:8] CONV_ACTIVE; endproperty
	a_cont: assert property (p_cont) else $error("not running");
	property p_ss;
		$rose(CONV_ACTIVE) && CFG_OUT[8] |-> |sclk_hist[15:2];
	endproperty
	a_ss: assert property (p_ss) else $error("stray start");
	property p_down; CFG_OUT[8] |-> act_cnt <= CONV_CYCLES + 4; endproperty
	a_down: assert property (p_down) else $error("no power-down");
	property p_rst; $rose(RESET_N) |-> CFG_OUT == CFG_RESET; endproperty
	a_rst: assert property (p_rst) else $error("config reset");
	c_frame: cover property ($fell(CS_N));
	c_conv: cover property ($rose(CONV_ACTIVE));
	c_cont: cover property (!CFG_OUT[8] && CONV_ACTIVE);
endmodule : asr_port_props
bind asr_port asr_port_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES),
	.CONV_CYCLES(CONV_CYCLES)) i_props (.CLK_SYS(CLK_SYS),
	.RESET_N(RESET_N), .CS_N(CS_N), .SCLK(SCLK), .DIN(DIN),
	.DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE), .DOUT_PULLUP(DOUT_PULLUP),
	.ADC_SAMPLE(ADC_SAMPLE), .CONV_ACTIVE(CONV_ACTIVE),
	.CFG_OUT(CFG_OUT));
`default_nettype wire

// [testbench/asr_ctl_model.sv]
`timescale 1ns/1ns
`default_nettype none
module asr_ctl_model (
	// Clock
	input wire logic clk,
	// Serial pins
	output logic cs_n,
	output logic sclk,
	output logic din,
	input wire logic dout
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		din = 1'b0;
	end
	task automatic sel(input logic v);
		@(negedge clk);
		cs_n = v;
	endtask : sel
	// Data set on rise; bit read just after the fall
	task automatic xfer(input logic [31:0] tx, input int nbits,
		input int half, output logic [31:0] rx);
		rx = '0;
		for (int i = 0; i < nbits; i++) begin
			sclk = 1'b1;
			din = tx[31 - i];
			repeat (half) @(negedge clk);
			sclk = 1'b0;
			@(negedge clk);
			rx = {rx[30:0], dout};
			repeat (half - 1) @(negedge clk);
		end
	endtask : xfer
endmodule : asr_ctl_model
`default_nettype wire

// [testbench/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import asr_pkg::*;
	localparam int unsigned TO_CYC = 200;
	localparam int unsigned CV_CYC = 1200;
	logic clk_sys, reset_n, cs_n, sclk, din, dout_o, dout_oe, dout_pullup;
	logic conv_active, dout_pin, dout_last;
	logic signed [SAMPLE_W-1:0] adc_sample;
	logic [WORD_BITS-1:0] cfg_out;
	logic [31:0] rx;
	int bad_count, check_count, n;
	logic signed [13:0] smp [4] = '{14'sh0800, 14'sh37FF, 14'sh3FFF, 14'sh0001};
	logic [15:0] res [4] = '{16'h7FF0, 16'h8000, 16'hFFF0, 16'h0010};
	// Released pin: pull-up, else a value that keeps changing
	assign dout_pin = dout_oe ? dout_o : (dout_pullup ? 1'b1 : ~dout_last);
	always @(posedge clk_sys) dout_last <= dout_pin;
	asr_port #(.TIMEOUT_CYCLES(TO_CYC), .CONV_CYCLES(CV_CYC)) i_dut (
		.CLK_SYS(clk_sys), .RESET_N(reset_n), .CS_N(cs_n), .SCLK(sclk),
		.DIN(din), .DOUT_O(dout_o), .DOUT_OE(dout_oe),
		.DOUT_PULLUP(dout_pullup), .ADC_SAMPLE(adc_sample),
		.CONV_ACTIVE(conv_active), .CFG_OUT(cfg_out));
	asr_ctl_model i_ctl (.clk(clk_sys), .cs_n(cs_n), .sclk(sclk),
		.din(din), .dout(dout_pin));
	// ========
	// Helpers
	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic conclude;
		if (bad_count == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : conclude
	task automatic frame(input logic [15:0] cfg, input int nbits);
		i_ctl.sel(1'b0);
		repeat (6) @(negedge clk_sys);
		i_ctl.xfer(nbits == 32 ? {cfg, cfg} : {cfg, 16'h0000}, nbits, 4, rx);
		i_ctl.sel(1'b1);
		repeat (6) @(negedge clk_sys);
	endtask : frame
	task automatic wait_lvl(input logic v);
		n = 0;
		while (dout_pin !== v && n < 2 * CV_CYC) begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 2 * CV_CYC) chk("level wait", v, dout_pin);
	endtask : wait_lvl
	// ========
	// Stimulus
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	initial begin
		repeat (60000) @(posedge clk_sys);
		bad_count++;
		conclude();
	end
	initial begin
		reset_n = 1'b0;
		adc_sample = '0;
		repeat (20) @(negedge clk_sys);
		reset_n = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("cfg", CFG_RESET, cfg_out);
		chk("pullup", 1, dout_pullup);
		frame(16'hFFFF, 32);
		chk("first read", {RESULT_RESET, CFG_RESET}, rx);
		chk("no start", 0, conv_active);
		for (int k = 0; k < 4; k++) begin
			adc_sample = smp[k];
			frame(CFG_RESET | 16'h8000, 16);
			i_ctl.sel(1'b0);
			wait_lvl(1'b0);
			chk("ready", 0, dout_pin);
			chk("down", 0, conv_active);
			frame(CFG_RESET, 32);
			chk("result", {res[k], CFG_RESET}, rx);
		end
		frame(CFG_RESET, 16);
		chk("repeat", 32'h0000_0010, rx);
		i_ctl.sel(1'b0);
		repeat (6) @(negedge clk_sys);
		chk("no new", 1, dout_pin);
		i_ctl.xfer(32'hFFFF_FFFF, 5, 4, rx);
		repeat (TO_CYC + 20) @(negedge clk_sys);
		i_ctl.xfer({2{CFG_RESET}}, 32, 4, rx);
		chk("after stall", {16'h0010, CFG_RESET}, rx);
		frame(16'h0583, 32);
		chk("pull off", {16'h0010, 16'h0583}, rx);
		chk("pull released", 0, dout_pullup);
		chk("released", 0, dout_oe);
		frame(16'h0483, 32);
		adc_sample = 14'sh0005;
		i_ctl.sel(1'b0);
		// Pin floats without pull-up until the driver turns on
		repeat (4) @(negedge clk_sys);
		wait_lvl(1'b0);
		wait_lvl(1'b1);
		wait_lvl(1'b0);
		chk("lead", 1, n >= DRDY_LEAD_CYCLES && n <= DRDY_LEAD_CYCLES + 4);
		frame(16'h0483, 32);
		chk("cont read", {16'h0050, 16'h0483}, rx);
		repeat (10) @(negedge clk_sys);
		chk("running", 1, conv_active);
		conclude();
	end
endmodule : tb_top
`default_nettype wire
